// ---- design/css_core.sv ----
// Purpose: Selects and glitch-free switches the device clock source.
// Assumes: Control words arrive as ports in this domain; only the select and frequency words have write strobes.
// Notes:   The device clock output is a sampled replica of the chosen source.
`timescale 1ns/10ps

// Behaviour
// - Select field picks primary, secondary or internal.
// - Writing select starts switch once old source is low.
// - Any reset clears select field to primary.
// - Frequency field picks RC, 8 MHz or postscaled.
// - Frequency change acts at once on internal output.
// - Reset sets internal frequency to 1 MHz.
// - Code 000 uses divide-by-256 or low-power RC.
// - Watchdog clock always uses low-power RC.
// - Primary flag needs startup timer and primary driving.
// - Internal flag needs stable block driving clock.
// - Secondary flag set while secondary drives clock.
// - At most one running flag set.
// - Sleep enters idle or full sleep by bit.
// - Secondary select ignored while secondary disabled.
// - Pause two old plus three new edges.
module css_core #(
  parameter int OLD_EDGES = css_pkg::CSS_OLD_EDGES,
  parameter int NEW_EDGES = css_pkg::CSS_NEW_EDGES
) (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         sys_rst_in,
  // Oscillator source pins
  input  wire logic                         primary_clk_in,
  input  wire logic                         secondary_clk_in,
  input  wire logic                         main_internal_oscillator_in,
  input  wire logic                         low_power_rc_source_in,
  // Source status from the oscillators
  input  wire logic [3:0]                   primary_oscillator_config_in,
  input  wire logic                         oscillator_startup_timer_done_in,
  input  wire logic                         internal_block_stable_in,
  // Control words and strobes
  input  wire logic                         clock_source_select_wr_in,
  input  wire logic [1:0]                   clock_source_select_in,
  input  wire logic                         internal_freq_select_wr_in,
  input  wire logic [2:0]                   internal_freq_select_in,
  input  wire logic [7:0]                   oscillator_tuning_register_in,
  input  wire logic [7:0]                   secondary_timer_control_register_in,
  input  wire logic                         idle_on_sleep_select_in,
  input  wire logic                         sleep_instr_in,
  // Clocks out
  output logic                              device_clk_out,
  output logic                              watchdog_clk_out,
  // Status
  output logic [1:0]                        clock_source_select_out,
  output logic [2:0]                        internal_freq_select_out,
  output css_pkg::css_src_t                 active_source_out,
  output logic                              switching_out,
  output logic                              primary_clock_running_flag_out,
  output logic                              internal_clock_stable_flag_out,
  output logic                              secondary_clock_running_flag_out,
  output logic                              sleep_enter_out,
  output logic                              idle_enter_out
);
  import css_pkg::*;

  // ****************************************************************
  // Parameter checks and state
  // ****************************************************************
  if (OLD_EDGES < 1 || OLD_EDGES > 3 || NEW_EDGES < 1 || NEW_EDGES > 3) begin : g_chk
    $error("Edge counts must lie between 1 and 3.");
  end

  localparam logic [1:0] OLD_LAST = 2'(OLD_EDGES - 1);
  localparam logic [1:0] NEW_LAST = 2'(NEW_EDGES - 1);

  typedef struct packed {
    css_state_t           st;
    logic [1:0]           scs;
    logic [2:0]           ifs;
    css_src_t             act;
    css_src_t             tgt;
    logic [1:0]           cnt;
    logic [CSS_DIV_W-1:0] div;
    logic [2:0]           lv_prev;
    logic                 clk_o;
    logic                 pri_f;
    logic                 int_f;
    logic                 sec_f;
    logic                 sleep_o;
    logic                 idle_o;
  } css_regs_t;

  css_regs_t q_r;
  css_regs_t q_nxt;

  css_sync_if pri_s ();
  css_sync_if sec_s ();
  css_sync_if osc_s ();
  css_sync_if lprc_s ();

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  css_sync u_pri  (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                   .raw_in(primary_clk_in), .sync_out(pri_s));
  css_sync u_sec  (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                   .raw_in(secondary_clk_in), .sync_out(sec_s));
  css_sync u_osc  (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                   .raw_in(main_internal_oscillator_in), .sync_out(osc_s));
  css_sync u_lprc (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                   .raw_in(low_power_rc_source_in), .sync_out(lprc_s));

  // ****************************************************************
  // Source levels and edges
  // ****************************************************************
  logic       low_freq_source_select;
  logic       sec_en;
  logic       pri_is_int;
  logic       lf_on_rc;
  logic       int_lvl;
  logic [2:0] lv;
  logic [2:0] rise;
  css_src_t   req;

  assign low_freq_source_select     = oscillator_tuning_register_in[CSS_LOW_FREQ_SOURCE_SELECT_BIT];
  assign sec_en     = secondary_timer_control_register_in[CSS_SEC_EN_BIT];
  assign pri_is_int = (primary_oscillator_config_in == CSS_PRI_INTIO_A) ||
                      (primary_oscillator_config_in == CSS_PRI_INTIO_B);
  assign lf_on_rc   = (q_r.ifs == CSS_IFS_LF) && !low_freq_source_select;
  assign watchdog_clk_out = lprc_s.level;
  // Decode the select field; upper bit set means internal block.
  assign req = q_r.scs[1] ? CSS_SRC_INT : (q_r.scs[0] ? CSS_SRC_SEC : CSS_SRC_PRI);

  // Internal block output follows the live field with no switch pause.
  always_comb begin
    case (q_r.ifs)
      3'h7:    int_lvl = osc_s.level;
      3'h6:    int_lvl = q_r.div[0];
      3'h5:    int_lvl = q_r.div[1];
      3'h4:    int_lvl = q_r.div[2];
      3'h3:    int_lvl = q_r.div[3];
      3'h2:    int_lvl = q_r.div[4];
      3'h1:    int_lvl = q_r.div[5];
      default: int_lvl = low_freq_source_select ? q_r.div[7] : lprc_s.level;
    endcase
  end

  // Levels indexed by source code, and their rising edges.
  assign lv[CSS_SRC_PRI] = pri_is_int ? int_lvl : pri_s.level;
  assign lv[CSS_SRC_SEC] = sec_s.level;
  assign lv[CSS_SRC_INT] = int_lvl;
  assign rise            = lv & ~q_r.lv_prev;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    q_nxt         = q_r;
    q_nxt.lv_prev = lv;
    if (osc_s.rise) begin
      q_nxt.div = q_r.div + 8'h01;
    end
    // Secondary request is dropped while its oscillator is off.
    if (clock_source_select_wr_in &&
        !((clock_source_select_in == CSS_SCS_SEC) && !sec_en)) begin
      q_nxt.scs = clock_source_select_in;
    end
    if (internal_freq_select_wr_in) begin
      q_nxt.ifs = internal_freq_select_in;
    end
    // Switch sequence: wait for old low, count old edges, count new edges.
    case (q_r.st)
      CSS_ST_RUN: begin
        if (req != q_r.act && !lv[q_r.act]) begin
          q_nxt.st  = CSS_ST_OLD;
          q_nxt.tgt = req;
          q_nxt.cnt = 2'h0;
        end
      end
      CSS_ST_OLD: begin
        if (rise[q_r.act]) begin
          q_nxt.cnt = q_r.cnt + 2'h1;
          if (q_r.cnt == OLD_LAST) begin
            q_nxt.st  = CSS_ST_NEW;
            q_nxt.cnt = 2'h0;
          end
        end
      end
      CSS_ST_NEW: begin
        if (rise[q_r.tgt]) begin
          q_nxt.cnt = q_r.cnt + 2'h1;
          if (q_r.cnt == NEW_LAST) begin
            q_nxt.st  = CSS_ST_RUN;
            q_nxt.act = q_r.tgt;
            q_nxt.cnt = 2'h0;
          end
        end
      end
      default: begin
        q_nxt.st = CSS_ST_RUN;
      end
    endcase
    // Output held low through the pause, then follows the new source.
    q_nxt.clk_o = (q_nxt.st == CSS_ST_RUN) && lv[q_nxt.act];
    // Flags are driven by hardware only, from the active source.
    q_nxt.pri_f = (q_nxt.st == CSS_ST_RUN) && (q_nxt.act == CSS_SRC_PRI) &&
                  !pri_is_int && oscillator_startup_timer_done_in;
    q_nxt.int_f = (q_nxt.st == CSS_ST_RUN) && internal_block_stable_in && !lf_on_rc &&
                  ((q_nxt.act == CSS_SRC_INT) ||
                   ((q_nxt.act == CSS_SRC_PRI) && pri_is_int));
    q_nxt.sec_f = (q_nxt.st == CSS_ST_RUN) && (q_nxt.act == CSS_SRC_SEC);
    // Sleep instruction chooses idle or full sleep.
    q_nxt.sleep_o = sleep_instr_in && !idle_on_sleep_select_in;
    q_nxt.idle_o  = sleep_instr_in && idle_on_sleep_select_in;
  end

  // Register the state; reset returns to primary at 1 MHz.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q_r     <= '0;
      q_r.scs <= CSS_SCS_RST;
      q_r.ifs <= CSS_IFS_RST;
      q_r.act <= CSS_SRC_PRI;
      q_r.tgt <= CSS_SRC_PRI;
      q_r.st  <= CSS_ST_RUN;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign device_clk_out                   = q_r.clk_o;
  assign clock_source_select_out          = q_r.scs;
  assign internal_freq_select_out         = q_r.ifs;
  assign active_source_out                = q_r.act;
  assign switching_out                    = (q_r.st != CSS_ST_RUN);
  assign primary_clock_running_flag_out   = q_r.pri_f;
  assign internal_clock_stable_flag_out   = q_r.int_f;
  assign secondary_clock_running_flag_out = q_r.sec_f;
  assign sleep_enter_out                  = q_r.sleep_o;
  assign idle_enter_out                   = q_r.idle_o;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_old_last;
    (q_r.st == CSS_ST_OLD) && rise[q_r.act] && (q_r.cnt == OLD_LAST);
  endsequence
  sequence s_new_last;
    (q_r.st == CSS_ST_NEW) && rise[q_r.tgt] && (q_r.cnt == NEW_LAST);
  endsequence

  a_reset_defaults: assert property (disable iff (1'b0)
    sys_rst_in |=> (q_r.scs == CSS_SCS_RST) && (q_r.ifs == CSS_IFS_RST) &&
                   (q_r.act == CSS_SRC_PRI))
    else $error("Reset did not restore select and frequency fields.");
  a_sec_ignored: assert property (
    clock_source_select_wr_in && (clock_source_select_in == CSS_SCS_SEC) && !sec_en
    |=> q_r.scs == $past(q_r.scs))
    else $error("Secondary select taken while secondary oscillator disabled.");
  a_switch_start: assert property (
    (q_r.st == CSS_ST_RUN) && (req != q_r.act) && !lv[q_r.act]
    |=> (q_r.st == CSS_ST_OLD) && (q_r.tgt == $past(req)))
    else $error("Switch did not start after select change.");
  a_old_to_new: assert property (
    s_old_last |=> (q_r.st == CSS_ST_NEW) && (q_r.cnt == 2'h0))
    else $error("Old-source edge count did not end the first pause phase.");
  a_new_done: assert property (
    s_new_last |=> (q_r.st == CSS_ST_RUN) && (q_r.act == $past(q_r.tgt)))
    else $error("Switch did not complete after new-source edges.");
  a_pause_low: assert property (
    (q_r.st != CSS_ST_RUN) |-> !device_clk_out)
    else $error("Device clock not held low during switch.");
  a_flags_onehot: assert property (
    $onehot0({q_r.pri_f, q_r.int_f, q_r.sec_f}))
    else $error("More than one clock running flag set.");
  a_pri_flag: assert property (
    q_r.pri_f |-> $past(oscillator_startup_timer_done_in) && (q_r.act == CSS_SRC_PRI))
    else $error("Primary flag set without startup timer done.");
  a_int_flag: assert property (
    q_r.int_f |-> $past(internal_block_stable_in) && !switching_out)
    else $error("Internal flag set without stable block.");
  a_sec_flag: assert property (
    q_r.sec_f |-> (q_r.act == CSS_SRC_SEC) && (q_r.st == CSS_ST_RUN))
    else $error("Secondary flag set while secondary not driving.");
  a_sleep_mode: assert property (
    sleep_instr_in |=> (idle_enter_out == $past(idle_on_sleep_select_in)) &&
                       (sleep_enter_out == !$past(idle_on_sleep_select_in)))
    else $error("Sleep instruction entered the wrong mode.");
endmodule

// ---- design/css_pkg.sv ----
// Purpose: Shared constants and types for the system clock source selector.
// Assumes: One 10 MHz system clock; oscillator sources arrive as pins.
// Notes:   Field positions refer to the 8-bit control words given as ports.
package css_pkg;

  // ****************************************************************
  // Timing and field constants
  // ****************************************************************
  localparam int       CSS_CLK_PERIOD_NS = 100;
  localparam int       CSS_OLD_EDGES     = 2;
  localparam int       CSS_NEW_EDGES     = 3;
  localparam logic [1:0] CSS_SCS_RST     = 2'h0;
  localparam logic [1:0] CSS_SCS_SEC     = 2'h1;
  localparam logic [2:0] CSS_IFS_RST     = 3'h4;
  localparam logic [2:0] CSS_IFS_LF      = 3'h0;
  localparam logic [2:0] CSS_IFS_MAX     = 3'h7;
  localparam int       CSS_SEC_EN_BIT    = 3;
  localparam int       CSS_SEC_RUN_BIT   = 6;
  localparam int       CSS_LOW_FREQ_SOURCE_SELECT_BIT    = 7;
  localparam int       CSS_DIV_W         = 8;
  // Primary configurations that use the internal block as primary clock.
  localparam logic [3:0] CSS_PRI_INTIO_A = 4'h8;
  localparam logic [3:0] CSS_PRI_INTIO_B = 4'h9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CSS_SRC_PRI = 2'h0,
    CSS_SRC_SEC = 2'h1,
    CSS_SRC_INT = 2'h2
  } css_src_t;

  typedef enum logic [1:0] {
    CSS_ST_RUN = 2'h0,
    CSS_ST_OLD = 2'h1,
    CSS_ST_NEW = 2'h3
  } css_state_t;

endpackage

// ---- design/css_sync.sv ----
// Purpose: Two-flop synchroniser with rising edge detect for one source pin.
// Assumes: The pin toggles slower than half the system clock rate.
// Notes:   The first flop feeds only the second flop.
`timescale 1ns/10ps
module css_sync (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Raw pin
  input  wire logic  raw_in,
  // Synchronised result
  css_sync_if.src    sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } css_sync_t;

  css_sync_t q_r;
  css_sync_t q_nxt;

  // Shift the pin through the synchroniser and keep one older copy.
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = raw_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
  end

  // Register the state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Level and rise are read from the second and third flops only.
  assign sync_out.level = q_r.s2;
  assign sync_out.rise  = q_r.s2 & ~q_r.s3;
endmodule

// ---- design/css_sync_if.sv ----
// Purpose: Carries a synchronised oscillator level and its rising edge.
// Assumes: Driven by css_sync, read by the selector core.
// Notes:   Both signals are in the system clock domain.
`timescale 1ns/10ps
interface css_sync_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ---- testbench/css_core_tb_top.sv ----
// Purpose: Self-checking bench for the clock source selector core.
// Assumes: Oscillator pins are made here as divided copies of clk_in.
// Notes:   Pin rates: internal 2.5 MHz, primary 1.25 MHz, RC 625 kHz, secondary 312 kHz.
`timescale 1ns/10ps
module css_core_tb_top;
  import css_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic       clk_in, sys_rst_in, scs_wr, ifs_wr, t_done, stable, idle_sel, sleep_i;
  logic [1:0] scs_d;
  logic [2:0] ifs_d;
  logic [7:0] tune, t1ctl, cyc;
  logic [3:0] fosc;
  logic       dev_clk, wdt_clk, sw, f_pri, f_int, f_sec, slp, idl;
  logic [1:0] scs_q;
  logic [2:0] ifs_q;
  css_src_t   act;
  int         error_cnt, checked, nd, nw, n, c;

  // The clock runs at 10 MHz.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Oscillator pins advance with a free counter at each rising edge; reset clears it.
  always @(posedge clk_in) begin
    cyc <= sys_rst_in ? 8'h00 : cyc + 8'h01;
  end

  css_core #(.OLD_EDGES(2), .NEW_EDGES(3)) i_dut (
    .clk_in                              (clk_in),
    .sys_rst_in                          (sys_rst_in),
    .primary_clk_in                      (cyc[2]),
    .secondary_clk_in                    (cyc[4]),
    .main_internal_oscillator_in         (cyc[1]),
    .low_power_rc_source_in              (cyc[3]),
    .primary_oscillator_config_in        (fosc),
    .oscillator_startup_timer_done_in    (t_done),
    .internal_block_stable_in            (stable),
    .clock_source_select_wr_in           (scs_wr),
    .clock_source_select_in              (scs_d),
    .internal_freq_select_wr_in          (ifs_wr),
    .internal_freq_select_in             (ifs_d),
    .oscillator_tuning_register_in       (tune),
    .secondary_timer_control_register_in (t1ctl),
    .idle_on_sleep_select_in             (idle_sel),
    .sleep_instr_in                      (sleep_i),
    .device_clk_out                      (dev_clk),
    .watchdog_clk_out                    (wdt_clk),
    .clock_source_select_out             (scs_q),
    .internal_freq_select_out            (ifs_q),
    .active_source_out                   (act),
    .switching_out                       (sw),
    .primary_clock_running_flag_out      (f_pri),
    .internal_clock_stable_flag_out      (f_int),
    .secondary_clock_running_flag_out    (f_sec),
    .sleep_enter_out                     (slp),
    .idle_enter_out                      (idl)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pulses one write strobe for a cycle; fields read back one cycle later.
  task automatic wr(input bit freq, input logic [2:0] v);
    @(posedge clk_in);
    if (freq) begin
      ifs_wr <= 1'b1;
      ifs_d  <= v;
    end else begin
      scs_wr <= 1'b1;
      scs_d  <= v[1:0];
    end
    @(posedge clk_in);
    ifs_wr <= 1'b0;
    scs_wr <= 1'b0;
    @(negedge clk_in);
  endtask

  // Waits for the pause flag under a bound; the clock is held low meanwhile.
  task automatic wait_sw(input logic v, input int lim);
    int i;
    n = 0;
    for (i = 0; i < lim && sw !== v; i++) begin
      @(negedge clk_in);
      n++;
      if (sw === 1'b1) check({15'h0, dev_clk}, 16'h0);
    end
    if (sw !== v) begin
      error_cnt++;
      $display("BAD %0t switch wait expired", $time);
      finish_test();
    end
  endtask

  // Writes the select field and checks the whole switch and the flags after it.
  task automatic switch_to(input logic [1:0] v, input css_src_t exp);
    wr(1'b0, {1'b0, v});
    check({14'h0, scs_q}, {14'h0, v});
    wait_sw(1'b1, 20);
    wait_sw(1'b0, 400);
    check({15'h0, n >= 12}, 16'h1);
    check({14'h0, act}, {14'h0, exp});
    check({13'h0, f_pri, f_int, f_sec},
          {13'h0, exp == CSS_SRC_PRI, exp == CSS_SRC_INT, exp == CSS_SRC_SEC});
  endtask

  // Counts rising edges of the device and watchdog clocks over 256 cycles.
  task automatic measure();
    logic pd, pw;
    int   i;
    nd = 0;
    nw = 0;
    pd = dev_clk;
    pw = wdt_clk;
    for (i = 0; i < 256; i++) begin
      @(negedge clk_in);
      if (dev_clk === 1'b1 && pd === 1'b0) nd++;
      if (wdt_clk === 1'b1 && pw === 1'b0) nw++;
      pd = dev_clk;
      pw = wdt_clk;
    end
  endtask

  // Executes a sleep instruction and counts the two entry pulses.
  task automatic do_sleep(input logic idle, input int exp_s, input int exp_i);
    int i, ns, ni;
    ns = 0;
    ni = 0;
    @(posedge clk_in);
    idle_sel <= idle;
    sleep_i  <= 1'b1;
    @(posedge clk_in);
    sleep_i  <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(negedge clk_in);
      if (slp === 1'b1) ns++;
      if (idl === 1'b1) ni++;
    end
    check(16'(ns), 16'(exp_s));
    check(16'(ni), 16'(exp_i));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {sys_rst_in, scs_wr, ifs_wr, t_done, stable, idle_sel, sleep_i} = 7'b1000100;
    {scs_d, ifs_d, tune, t1ctl, fosc} = '0;
    error_cnt = 0;
    checked = 0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check({11'h0, scs_q, ifs_q}, {11'h0, CSS_SCS_RST, CSS_IFS_RST});
    check({12'h0, act, sw, dev_clk}, 16'h0);
    check({13'h0, f_pri, f_int, f_sec}, 16'h0);
    @(posedge clk_in);
    t_done <= 1'b1;
    repeat (3) @(negedge clk_in);
    check({13'h0, f_pri, f_int, f_sec}, 16'h4);
    // Secondary oscillator off: the request leaves everything alone.
    wr(1'b0, 3'h1);
    repeat (10) @(negedge clk_in);
    check({12'h0, scs_q, sw, act == CSS_SRC_PRI}, 16'h1);
    switch_to(2'h3, CSS_SRC_INT);
    // Postscaler codes: code c gives 256 >> (9 - c) rises in 256 cycles.
    for (c = 7; c >= 1; c--) begin
      wr(1'b1, 3'(c));
      check({13'h0, ifs_q}, 16'(c));
      measure();
      check({15'h0, sw}, 16'h0);
      check({15'h0, nd >= (256 >> (9 - c)) - 2 && nd <= (256 >> (9 - c)) + 2}, 16'h1);
    end
    // Code 000 picks the RC source with bit 7 clear, 8 MHz / 256 with it set.
    wr(1'b1, CSS_IFS_LF);
    measure();
    check({15'h0, nd >= 14 && nd <= 18}, 16'h1);
    check({15'h0, nw >= 14 && nw <= 18}, 16'h1);
    check({13'h0, f_pri, f_int, f_sec}, 16'h0);
    @(posedge clk_in);
    tune <= 8'h80;
    @(negedge clk_in);
    measure();
    check({15'h0, nd <= 1}, 16'h1);
    check({15'h0, nw >= 14 && nw <= 18}, 16'h1);
    wr(1'b1, CSS_IFS_MAX);
    // The secondary oscillator is enabled and running before it is chosen.
    @(posedge clk_in);
    t1ctl <= 8'h08;
    repeat (4) @(negedge clk_in);
    switch_to(2'h1, CSS_SRC_SEC);
    switch_to(2'h0, CSS_SRC_PRI);
    switch_to(2'h2, CSS_SRC_INT);
    do_sleep(1'b0, 1, 0);
    do_sleep(1'b1, 0, 1);
    // A reset in mid-run returns both fields and the source to their defaults.
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check({11'h0, scs_q, ifs_q}, {11'h0, CSS_SCS_RST, CSS_IFS_RST});
    check({14'h0, act}, {14'h0, CSS_SRC_PRI});
    // With the internal block as primary, the internal flag replaces the primary one.
    @(posedge clk_in);
    fosc <= CSS_PRI_INTIO_A;
    repeat (3) @(negedge clk_in);
    check({13'h0, f_pri, f_int, f_sec}, 16'h2);
    finish_test();
  end
endmodule
